//--- rtl/rxs_pkg.sv
// Shared constants and types of the receive status flag block
package rxs_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] RXS_OFF_CTRL = 8'h00;
  localparam logic [7:0] RXS_OFF_MAX_LEN = 8'h04;
  localparam logic [7:0] RXS_OFF_STATUS = 8'h08;
  localparam logic [7:0] RXS_OFF_INT_STATUS = 8'h0C;
  localparam logic [7:0] RXS_OFF_INT_MASK = 8'h10;
  localparam logic [7:0] RXS_OFF_MISMATCH = 8'h14;

  // Control register fields
  localparam int RXS_CTRL_W = 2;
  localparam int RXS_CTRL_RX_TEST = 0;
  localparam int RXS_CTRL_TX_TEST = 1;
  localparam logic [1:0] RXS_CTRL_RESET = 2'h0;
  localparam logic [14:0] RXS_MAX_LEN_RESET = 15'h2580;

  // Level status register fields
  localparam int RXS_ST_LOCAL = 0;
  localparam int RXS_ST_INTERNAL = 1;
  localparam int RXS_ST_RECEIVED = 2;
  localparam int RXS_ST_REMOTE = 3;

  // Event bits of the interrupt status and mask registers
  localparam int RXS_EV_W = 7;
  localparam int RXS_EV_BAD_PREAMBLE = 0;
  localparam int RXS_EV_BAD_START = 1;
  localparam int RXS_EV_SIGNAL_OS = 2;
  localparam int RXS_EV_MISMATCH = 3;
  localparam int RXS_EV_TRUNCATED = 4;
  localparam int RXS_EV_LOCAL_FAULT = 5;
  localparam int RXS_EV_REMOTE_FAULT = 6;
  localparam logic [6:0] RXS_MASK_RESET = 7'h00;

  // AXI responses
  localparam logic [1:0] RXS_RESP_OKAY = 2'h0;
  localparam logic [1:0] RXS_RESP_SLVERR = 2'h2;

  // Received word coding (64-bit data, 8 control flags, byte 0 first)
  localparam logic [7:0] RXS_CTL_FIRST = 8'h01;
  localparam logic [7:0] RXS_CODE_START = 8'hFB;
  localparam logic [7:0] RXS_CODE_PREAMBLE = 8'h55;
  localparam logic [7:0] RXS_CODE_SFD = 8'hD5;
  localparam logic [7:0] RXS_CODE_SIGNAL_OS = 8'h5C;
  localparam logic [7:0] RXS_CODE_SEQ_OS = 8'h9C;
  localparam logic [23:0] RXS_SEQ_LOCAL = 24'h010000;
  localparam logic [23:0] RXS_SEQ_REMOTE = 24'h020000;
  localparam logic [16:0] RXS_WORD_BYTES = 17'h00008;

  // Fault sequence machine: sequences needed, columns to clear
  localparam logic [2:0] RXS_FAULT_SEQ_CNT = 3'h4;
  localparam logic [6:0] RXS_FAULT_COL_LAST = 7'h7F;

  typedef enum logic [1:0] {
    RXS_FS_IDLE = 2'b00,
    RXS_FS_COUNT = 2'b01,
    RXS_FS_FAULT = 2'b10
  } rxs_fault_state_type;

endpackage : rxs_pkg

//--- rtl/rxs_fault_sm.sv
// Fault sequence qualifier for one kind of fault ordered set
`timescale 1ns/1ps
module rxs_fault_sm
  import rxs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic col_valid,
  input wire logic seq_match,
  input wire logic seq_other,
  output logic fault
);

  typedef struct packed {
    rxs_fault_state_type state;
    logic [2:0] seq_cnt;
    logic [6:0] col_cnt;
  } rxs_fsm_type;

  rxs_fsm_type s;
  rxs_fsm_type n;

  always_comb
  begin
    n = s;
    if (col_valid)
    begin
      if (seq_match)
      begin
        n.col_cnt = 7'h00;
        if (s.state == RXS_FS_FAULT || s.seq_cnt == RXS_FAULT_SEQ_CNT - 3'h1)
        begin
          n.state = RXS_FS_FAULT;
        end
        else
        begin
          n.state = RXS_FS_COUNT;
          n.seq_cnt = s.seq_cnt + 3'h1;
        end
      end
      else if (seq_other)
      begin
        // A different fault kind restarts the count
        n.state = RXS_FS_IDLE;
        n.seq_cnt = 3'h0;
        n.col_cnt = 7'h00;
      end
      else
      begin
        case (s.state)
          RXS_FS_IDLE:
          begin
            n.col_cnt = 7'h00;
          end
          RXS_FS_COUNT, RXS_FS_FAULT:
          begin
            if (s.col_cnt == RXS_FAULT_COL_LAST)
            begin
              n.state = RXS_FS_IDLE;
              n.seq_cnt = 3'h0;
              n.col_cnt = 7'h00;
            end
            else
            begin
              n.col_cnt = s.col_cnt + 7'h01;
            end
          end
          default:
          begin
            n.state = RXS_FS_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '{RXS_FS_IDLE, 3'h0, 7'h00};
    end
    else
    begin
      s <= n;
    end
  end

  assign fault = (s.state == RXS_FS_FAULT);

endmodule : rxs_fault_sm

//--- rtl/rxs_status_flags.sv
// Receive status and fault flags with AXI4-Lite control and interrupt
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module rxs_status_flags
  import rxs_pkg::*;
#(
  parameter logic [14:0] MAX_LEN_DEFAULT = RXS_MAX_LEN_RESET
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic rx_valid,
  input wire logic [63:0] rx_data,
  input wire logic [7:0] rx_ctrl,
  input wire logic [1:0] rx_block_err,
  input wire logic rx_lane_aligned,
  input wire logic rx_hi_ber,
  output logic rx_out_valid,
  output logic [63:0] rx_out_data,
  output logic [7:0] rx_out_ctrl,
  output logic rx_bad_preamble,
  output logic rx_bad_start_delim,
  output logic rx_signal_ordered_set_seen,
  output logic [1:0] rx_test_mismatch,
  output logic rx_truncated,
  output logic rx_local_fault,
  output logic rx_remote_fault,
  output logic rx_internal_local_fault,
  output logic rx_received_local_fault,
  output logic irq
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] ctrl;
    logic [14:0] max_len;
    logic [6:0] int_status;
    logic [6:0] int_mask;
    logic [15:0] mismatch_total;
    logic in_pkt;
    logic drop;
    logic [15:0] pkt_len;
    logic out_valid;
    logic [63:0] out_data;
    logic [7:0] out_ctrl;
    logic bad_pre;
    logic bad_start;
    logic sig_os;
    logic [1:0] mismatch;
    logic trunc;
    logic local_fault;
    logic remote_fault;
    logic internal_fault;
    logic received_fault;
    logic irq;
  } rxs_state_type;

  rxs_state_type s;
  rxs_state_type n;
  logic [6:0] ev;
  logic [31:0] wr_val;
  logic [16:0] len_sum;
  logic clr_int;
  logic clr_mismatch;
  logic first_word;
  logic seq_word;
  logic [1:0] seq_match;
  logic [1:0] seq_other;
  logic [1:0] fault_seen;
  logic [16:0] mm_sum;

  function automatic logic addr_ok(input logic [7:0] a);
    case ({a[7:2], 2'b00})
      RXS_OFF_CTRL, RXS_OFF_MAX_LEN, RXS_OFF_STATUS,
      RXS_OFF_INT_STATUS, RXS_OFF_INT_MASK, RXS_OFF_MISMATCH: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction : addr_ok

  function automatic logic [31:0] reg_view(input rxs_state_type st, input logic [7:0] a);
    reg_view = 32'h00000000;
    case ({a[7:2], 2'b00})
      RXS_OFF_CTRL: reg_view[RXS_CTRL_W-1:0] = st.ctrl;
      RXS_OFF_MAX_LEN: reg_view[14:0] = st.max_len;
      RXS_OFF_STATUS:
      begin
        reg_view[RXS_ST_LOCAL] = st.local_fault;
        reg_view[RXS_ST_INTERNAL] = st.internal_fault;
        reg_view[RXS_ST_RECEIVED] = st.received_fault;
        reg_view[RXS_ST_REMOTE] = st.remote_fault;
      end
      RXS_OFF_INT_STATUS: reg_view[RXS_EV_W-1:0] = st.int_status;
      RXS_OFF_INT_MASK: reg_view[RXS_EV_W-1:0] = st.int_mask;
      RXS_OFF_MISMATCH: reg_view[15:0] = st.mismatch_total;
      default: reg_view = 32'h00000000;
    endcase
  endfunction : reg_view

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction : merge

  // Ordered set decode: sequence sets carry the fault kind in the last lane byte
  assign first_word = rx_valid && rx_ctrl == RXS_CTL_FIRST;
  assign seq_word = first_word && rx_data[7:0] == RXS_CODE_SEQ_OS;

  // Index 0 qualifies local fault sets, index 1 remote fault sets
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_fault
      assign seq_match[g] = seq_word &&
        rx_data[31:8] == (g == 0 ? RXS_SEQ_LOCAL : RXS_SEQ_REMOTE);
      assign seq_other[g] = seq_word && !seq_match[g];
      rxs_fault_sm i_rxs_fault_sm (
        .aclk(aclk),
        .aresetn(aresetn),
        .col_valid(rx_valid),
        .seq_match(seq_match[g]),
        .seq_other(seq_other[g]),
        .fault(fault_seen[g])
      );
    end
  endgenerate

  always_comb
  begin
    n = s;
    clr_int = 1'b0;
    clr_mismatch = 1'b0;
    wr_val = merge(reg_view(s, s.awaddr), s.wdata, s.wstrb);
    len_sum = {1'b0, s.pkt_len} + RXS_WORD_BYTES;

    // Write channel: address and data taken in either order
    if (s.awready && s_axi_awvalid)
    begin
      n.awready = 1'b0;
      n.awaddr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid)
    begin
      n.wready = 1'b0;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (!s.awready && !s.wready && !s.bvalid)
    begin
      n.bvalid = 1'b1;
      n.bresp = addr_ok(s.awaddr) ? RXS_RESP_OKAY : RXS_RESP_SLVERR;
      case ({s.awaddr[7:2], 2'b00})
        RXS_OFF_CTRL: n.ctrl = wr_val[RXS_CTRL_W-1:0];
        RXS_OFF_MAX_LEN: n.max_len = wr_val[14:0];
        RXS_OFF_INT_MASK: n.int_mask = wr_val[RXS_EV_W-1:0];
        default: n.bresp = n.bresp;
      endcase
    end
    if (s.bvalid && s_axi_bready)
    begin
      n.bvalid = 1'b0;
      n.awready = 1'b1;
      n.wready = 1'b1;
    end

    // Read channel; interrupt status and mismatch registers clear when read
    if (s.arready && s_axi_arvalid)
    begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rdata = reg_view(s, s_axi_araddr);
      n.rresp = addr_ok(s_axi_araddr) ? RXS_RESP_OKAY : RXS_RESP_SLVERR;
      clr_int = {s_axi_araddr[7:2], 2'b00} == RXS_OFF_INT_STATUS;
      clr_mismatch = {s_axi_araddr[7:2], 2'b00} == RXS_OFF_MISMATCH;
    end
    if (s.rvalid && s_axi_rready)
    begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end

    // Per-word flags default to zero so each is a single-cycle pulse
    n.bad_pre = 1'b0;
    n.bad_start = 1'b0;
    n.trunc = 1'b0;
    n.out_valid = 1'b0;
    n.out_data = rx_data;
    n.out_ctrl = rx_ctrl;
    n.sig_os = first_word && rx_data[7:0] == RXS_CODE_SIGNAL_OS;

    if (first_word && rx_data[7:0] == RXS_CODE_START)
    begin
      n.bad_pre = rx_data[55:8] != {6{RXS_CODE_PREAMBLE}};
      n.bad_start = rx_data[63:56] != RXS_CODE_SFD;
      n.in_pkt = 1'b1;
      n.drop = 1'b0;
      n.pkt_len = 16'h0000;
      n.out_valid = 1'b1;
    end
    else if (rx_valid && s.in_pkt)
    begin
      if (rx_ctrl != 8'h00)
      begin
        // Terminating word closes the packet
        n.in_pkt = 1'b0;
        n.out_valid = !s.drop;
      end
      else if (!s.drop)
      begin
        if (len_sum > {2'b00, s.max_len})
        begin
          // Cut the packet here and discard the rest of it
          n.trunc = 1'b1;
          n.drop = 1'b1;
        end
        else
        begin
          n.out_valid = 1'b1;
          n.pkt_len = len_sum[15:0];
        end
      end
    end

    // Mismatch count of this cycle, held at zero outside test mode
    if (s.ctrl[RXS_CTRL_RX_TEST] && rx_valid)
    begin
      n.mismatch = {1'b0, rx_block_err[0]} + {1'b0, rx_block_err[1]};
    end
    else
    begin
      n.mismatch = 2'h0;
    end
    mm_sum = {1'b0, clr_mismatch ? 16'h0000 : s.mismatch_total} + {15'h0000, n.mismatch};
    n.mismatch_total = mm_sum[16] ? 16'hFFFF : mm_sum[15:0];

    // Fault levels
    n.internal_fault = s.ctrl[RXS_CTRL_TX_TEST] || !rx_lane_aligned || rx_hi_ber;
    n.received_fault = fault_seen[0];
    n.local_fault = n.internal_fault || n.received_fault;
    n.remote_fault = fault_seen[1];

    // Sticky events; a new event wins over a clearing read
    ev = 7'h00;
    ev[RXS_EV_BAD_PREAMBLE] = n.bad_pre;
    ev[RXS_EV_BAD_START] = n.bad_start;
    ev[RXS_EV_SIGNAL_OS] = n.sig_os;
    ev[RXS_EV_MISMATCH] = n.mismatch != 2'h0;
    ev[RXS_EV_TRUNCATED] = n.trunc;
    ev[RXS_EV_LOCAL_FAULT] = n.local_fault && !s.local_fault;
    ev[RXS_EV_REMOTE_FAULT] = n.remote_fault && !s.remote_fault;
    n.int_status = (clr_int ? 7'h00 : s.int_status) | ev;
    n.irq = |(n.int_status & n.int_mask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.ctrl <= RXS_CTRL_RESET;
      s.max_len <= MAX_LEN_DEFAULT;
      s.int_mask <= RXS_MASK_RESET;
    end
    else
    begin
      s <= n;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign rx_out_valid = s.out_valid;
  assign rx_out_data = s.out_data;
  assign rx_out_ctrl = s.out_ctrl;
  assign rx_bad_preamble = s.bad_pre;
  assign rx_bad_start_delim = s.bad_start;
  assign rx_signal_ordered_set_seen = s.sig_os;
  assign rx_test_mismatch = s.mismatch;
  assign rx_truncated = s.trunc;
  assign rx_local_fault = s.local_fault;
  assign rx_remote_fault = s.remote_fault;
  assign rx_internal_local_fault = s.internal_fault;
  assign rx_received_local_fault = s.received_fault;
  assign irq = s.irq;

endmodule : rxs_status_flags

//--- testbench/rxs_status_flags_assertions.sv
// Port checker of the receive status flag block
`timescale 1ns/1ps
module rxs_status_flags_assertions
  import rxs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rx_valid,
  input wire logic [63:0] rx_data,
  input wire logic [7:0] rx_ctrl,
  input wire logic [1:0] rx_block_err,
  input wire logic rx_lane_aligned,
  input wire logic rx_hi_ber,
  input wire logic rx_out_valid,
  input wire logic [63:0] rx_out_data,
  input wire logic [7:0] rx_out_ctrl,
  input wire logic rx_bad_preamble,
  input wire logic rx_bad_start_delim,
  input wire logic rx_signal_ordered_set_seen,
  input wire logic [1:0] rx_test_mismatch,
  input wire logic rx_truncated,
  input wire logic rx_local_fault,
  input wire logic rx_remote_fault,
  input wire logic rx_internal_local_fault,
  input wire logic rx_received_local_fault,
  input wire logic irq
);
  logic first_col;
  logic start_col;
  logic os_col;
  logic loc_col;
  logic rem_col;
  assign first_col = rx_valid && rx_ctrl == RXS_CTL_FIRST;
  assign start_col = first_col && rx_data[7:0] == RXS_CODE_START;
  assign os_col = first_col && rx_data[7:0] == RXS_CODE_SIGNAL_OS;
  assign loc_col = first_col && rx_data[31:0] == {RXS_SEQ_LOCAL, RXS_CODE_SEQ_OS};
  assign rem_col = first_col && rx_data[31:0] == {RXS_SEQ_REMOTE, RXS_CODE_SEQ_OS};
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_pre;
    start_col && rx_data[55:8] != {6{RXS_CODE_PREAMBLE}} |=> rx_bad_preamble;
  endproperty
  a_pre: assert property (p_pre) else $error("bad preamble missed");
  property p_sfd;
    start_col && rx_data[63:56] != RXS_CODE_SFD |=> rx_bad_start_delim;
  endproperty
  a_sfd: assert property (p_sfd) else $error("bad delimiter missed");
  property p_os;
    os_col |=> rx_signal_ordered_set_seen;
  endproperty
  a_os: assert property (p_os) else $error("signal set missed");
  property p_mis;
    rx_test_mismatch != 2'h0 |-> $past(rx_valid)
      && rx_test_mismatch == $countones($past(rx_block_err));
  endproperty
  a_mis: assert property (p_mis) else $error("mismatch count wrong");
  property p_trunc;
    rx_truncated |-> $past(rx_valid && rx_ctrl == 8'h00) && !rx_out_valid;
  endproperty
  a_trunc: assert property (p_trunc) else $error("truncation wrong");
  property p_drop;
    rx_truncated && rx_valid && rx_ctrl == 8'h00 |=> !rx_out_valid;
  endproperty
  a_drop: assert property (p_drop) else $error("column after cut forwarded");
  property p_fwd;
    start_col |=> rx_out_valid && rx_out_data == $past(rx_data)
      && rx_out_ctrl == $past(rx_ctrl);
  endproperty
  a_fwd: assert property (p_fwd) else $error("start column not forwarded");
  property p_loc;
    rx_local_fault == (rx_internal_local_fault || rx_received_local_fault);
  endproperty
  a_loc: assert property (p_loc) else $error("local fault not combined");
  property p_rem;
    $rose(rx_remote_fault) |-> $past(rem_col, 2);
  endproperty
  a_rem: assert property (p_rem) else $error("remote fault without cause");
  property p_int;
    !rx_lane_aligned || rx_hi_ber |=> rx_internal_local_fault;
  endproperty
  a_int: assert property (p_int) else $error("internal fault missed");
  property p_rcv;
    $rose(rx_received_local_fault) |-> $past(loc_col, 2);
  endproperty
  a_rcv: assert property (p_rcv) else $error("received fault without cause");
  property p_rst;
    disable iff (1'h0) !aresetn |=> !(rx_bad_preamble || rx_bad_start_delim || irq
      || rx_signal_ordered_set_seen || rx_test_mismatch != 2'h0 || rx_truncated
      || rx_local_fault || rx_remote_fault || rx_out_valid);
  endproperty
  a_rst: assert property (p_rst) else $error("output high in reset");
endmodule : rxs_status_flags_assertions
bind rxs_status_flags rxs_status_flags_assertions i_rxs_status_flags_assertions (.aclk,
  .aresetn, .rx_valid, .rx_data, .rx_ctrl, .rx_block_err, .rx_lane_aligned, .rx_hi_ber,
  .rx_out_valid, .rx_out_data, .rx_out_ctrl, .rx_bad_preamble, .rx_bad_start_delim,
  .rx_signal_ordered_set_seen,
  .rx_test_mismatch, .rx_truncated, .rx_local_fault, .rx_remote_fault,
  .rx_internal_local_fault, .rx_received_local_fault, .irq);

//--- testbench/rxs_link_partner.sv
// Behavioural link partner that sends receive columns
`timescale 1ns/1ps
module rxs_link_partner
  import rxs_pkg::*;
(
  input wire logic aclk,
  output logic rx_valid,
  output logic [63:0] rx_data,
  output logic [7:0] rx_ctrl,
  output logic [1:0] rx_block_err,
  output logic rx_lane_aligned,
  output logic rx_hi_ber
);
  initial
  begin
    rx_valid = 1'h0;
    rx_data = 64'h0;
    rx_ctrl = 8'h0;
    rx_block_err = 2'h0;
    rx_lane_aligned = 1'h1;
    rx_hi_ber = 1'h0;
  end
  task automatic col(input logic [63:0] d, input logic [7:0] c, input logic [1:0] e);
    @(posedge aclk);
    rx_valid <= 1'h1;
    rx_data <= d;
    rx_ctrl <= c;
    rx_block_err <= e;
  endtask : col
  // Idle lines show the inverse so stale data is never mistaken for a column
  task automatic done();
    @(posedge aclk);
    rx_valid <= 1'h0;
    rx_data <= ~rx_data;
    rx_ctrl <= ~rx_ctrl;
    rx_block_err <= 2'h0;
  endtask : done
  task automatic lane(input logic al, input logic hb);
    @(posedge aclk);
    rx_lane_aligned <= al;
    rx_hi_ber <= hb;
  endtask : lane
  task automatic seqs(input logic [23:0] kind, input int n);
    repeat (n) col({32'h0, kind, RXS_CODE_SEQ_OS}, RXS_CTL_FIRST, 2'h0);
    done();
  endtask : seqs
  task automatic idles(input int n);
    repeat (n) col(64'h0707070707070707, 8'hFF, 2'h0);
    done();
  endtask : idles
endmodule : rxs_link_partner

//--- testbench/rxs_status_flags_tb.sv
// Self-checking bench of the receive status flag block
`timescale 1ns/1ps
module rxs_status_flags_tb;
  import rxs_pkg::*;
  localparam logic [63:0] GOOD = {RXS_CODE_SFD, {6{RXS_CODE_PREAMBLE}}, RXS_CODE_START};
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0;
  logic [7:0] s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rx_block_err;
  logic [31:0] s_axi_rdata;
  logic rx_valid, rx_lane_aligned, rx_hi_ber;
  logic [63:0] rx_data;
  logic [7:0] rx_ctrl;
  logic [31:0] d;
  logic [1:0] r;
  int mismatches = 0;
  int samples_checked = 0;
  always #2.5 aclk = ~aclk;
  rxs_status_flags i_rxs_status_flags (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .rx_valid, .rx_data,
    .rx_ctrl, .rx_block_err, .rx_lane_aligned, .rx_hi_ber, .rx_out_valid(),
    .rx_out_data(), .rx_out_ctrl(), .rx_bad_preamble(), .rx_bad_start_delim(),
    .rx_signal_ordered_set_seen(), .rx_test_mismatch(), .rx_truncated(),
    .rx_local_fault(), .rx_remote_fault(), .rx_internal_local_fault(),
    .rx_received_local_fault(), .irq);
  rxs_link_partner i_rxs_link_partner (.aclk, .rx_valid, .rx_data, .rx_ctrl,
    .rx_block_err, .rx_lane_aligned, .rx_hi_ber);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw;
    logic w;
    aw = 1'h0;
    w = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'h1)
      begin
        aw = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w && s_axi_wready === 1'h1)
      begin
        w = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
    chk(r, RXS_RESP_OKAY);
  endtask : rdchk
  task automatic pkt(input logic [63:0] s, input int n);
    i_rxs_link_partner.col(s, RXS_CTL_FIRST, 2'h0);
    repeat (n) i_rxs_link_partner.col(64'h0123456789ABCDEF, 8'h00, 2'h0);
    i_rxs_link_partner.col(64'h07070707070707FD, 8'hFF, 2'h0);
    i_rxs_link_partner.done();
  endtask : pkt
  task automatic t_reset();
    rdchk(RXS_OFF_CTRL, 32'h0);
    rdchk(RXS_OFF_MAX_LEN, {17'h0, RXS_MAX_LEN_RESET});
    rdchk(RXS_OFF_INT_MASK, 32'h0);
    rd(8'h18);
    chk(r, RXS_RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h18, 32'h1);
    chk(r, RXS_RESP_SLVERR);
  endtask : t_reset
  task automatic t_start();
    pkt(GOOD ^ 64'h100, 1);
    pkt(GOOD ^ {8'h01, 56'h0}, 1);
    rdchk(RXS_OFF_INT_STATUS, 32'h3);
    pkt(GOOD, 1);
    rdchk(RXS_OFF_INT_STATUS, 32'h0);
  endtask : t_start
  task automatic t_os();
    wr(RXS_OFF_INT_MASK, 32'h4);
    chk(r, RXS_RESP_OKAY);
    chk(irq, 1'h0);
    i_rxs_link_partner.col({56'h0, RXS_CODE_SIGNAL_OS}, RXS_CTL_FIRST, 2'h0);
    i_rxs_link_partner.done();
    repeat (2) @(posedge aclk);
    chk(irq, 1'h1);
    rdchk(RXS_OFF_INT_STATUS, 32'h4);
    chk(irq, 1'h0);
    wr(RXS_OFF_INT_MASK, 32'h0);
  endtask : t_os
  task automatic t_mis();
    i_rxs_link_partner.col(64'h0707070707070707, 8'hFF, 2'h3);
    i_rxs_link_partner.done();
    rdchk(RXS_OFF_MISMATCH, 32'h0);
    wr(RXS_OFF_CTRL, 32'h1);
    i_rxs_link_partner.col(64'h0707070707070707, 8'hFF, 2'h3);
    i_rxs_link_partner.col(64'h0707070707070707, 8'hFF, 2'h1);
    i_rxs_link_partner.done();
    rdchk(RXS_OFF_MISMATCH, 32'h3);
    rdchk(RXS_OFF_INT_STATUS, 32'h8);
    wr(RXS_OFF_CTRL, 32'h0);
  endtask : t_mis
  task automatic t_trunc();
    wr(RXS_OFF_MAX_LEN, 32'h10);
    pkt(GOOD, 2);
    rdchk(RXS_OFF_INT_STATUS, 32'h0);
    pkt(GOOD, 3);
    pkt(GOOD, 4);
    rdchk(RXS_OFF_INT_STATUS, 32'h10);
  endtask : t_trunc
  task automatic t_fault();
    i_rxs_link_partner.lane(1'h0, 1'h0);
    rdchk(RXS_OFF_STATUS, 32'h3);
    i_rxs_link_partner.lane(1'h1, 1'h1);
    rdchk(RXS_OFF_STATUS, 32'h3);
    i_rxs_link_partner.lane(1'h1, 1'h0);
    rdchk(RXS_OFF_STATUS, 32'h0);
    rdchk(RXS_OFF_INT_STATUS, 32'h20);
    i_rxs_link_partner.seqs(RXS_SEQ_LOCAL, 3);
    rdchk(RXS_OFF_STATUS, 32'h0);
    i_rxs_link_partner.seqs(RXS_SEQ_LOCAL, 1);
    rdchk(RXS_OFF_STATUS, 32'h5);
    i_rxs_link_partner.idles(130);
    rdchk(RXS_OFF_STATUS, 32'h0);
    i_rxs_link_partner.seqs(RXS_SEQ_REMOTE, 4);
    rdchk(RXS_OFF_STATUS, 32'h8);
    i_rxs_link_partner.idles(130);
    rdchk(RXS_OFF_STATUS, 32'h0);
    rdchk(RXS_OFF_INT_STATUS, 32'h60);
  endtask : t_fault
  // Reset in mid-run must clear pending events, irq and the control registers
  task automatic t_rst();
    wr(RXS_OFF_INT_MASK, 32'h7F);
    wr(RXS_OFF_CTRL, 32'h1);
    i_rxs_link_partner.col({56'h0, RXS_CODE_SIGNAL_OS}, RXS_CTL_FIRST, 2'h0);
    i_rxs_link_partner.done();
    @(posedge aclk);
    chk(irq, 1'h1);
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    chk(irq, 1'h0);
    aresetn <= 1'h1;
    rdchk(RXS_OFF_CTRL, 32'h0);
    rdchk(RXS_OFF_MAX_LEN, {17'h0, RXS_MAX_LEN_RESET});
    rdchk(RXS_OFF_INT_MASK, 32'h0);
    rdchk(RXS_OFF_INT_STATUS, 32'h0);
  endtask : t_rst
  task automatic conclude();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  initial
  begin
    #200000;
    mismatches++;
    conclude();
  end
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_start();
    t_os();
    t_mis();
    t_trunc();
    t_fault();
    t_rst();
    conclude();
  end
endmodule : rxs_status_flags_tb
